//--- qstc_pkg.sv
// constants of the quarter-second time counter: register map, field layout,
// reset values, prescaler divisors and power mode codes.
// assumes a 32-bit Avalon-MM register port with one register per aligned word.
package qstc_pkg;

  // register byte offsets
  localparam logic [4:0] QSTC_OFS_CONTROL = 5'h00;
  localparam logic [4:0] QSTC_OFS_STATUS  = 5'h04;
  localparam logic [4:0] QSTC_OFS_COUNT   = 5'h08;
  localparam logic [4:0] QSTC_OFS_MATCH   = 5'h0C;
  localparam logic [4:0] QSTC_OFS_GATE    = 5'h10;

  // control register fields
  localparam int QSTC_CTL_ENABLE   = 7;
  localparam int QSTC_CTL_SRC_HI   = 6;
  localparam int QSTC_CTL_SRC_LO   = 5;
  localparam int QSTC_CTL_CLEAR    = 4;
  localparam int QSTC_CTL_CLKOUT   = 3;
  localparam int QSTC_CTL_PS_HI    = 2;
  localparam int QSTC_CTL_PS_LO    = 0;

  // status register fields
  localparam int QSTC_ST_QSEC_F    = 7;
  localparam int QSTC_ST_SEC_F     = 6;
  localparam int QSTC_ST_MATCH_F   = 5;
  localparam int QSTC_ST_QSEC_IE   = 4;
  localparam int QSTC_ST_SEC_IE    = 3;
  localparam int QSTC_ST_MATCH_IE  = 2;

  // match register fields
  localparam int QSTC_MT_ENABLE    = 7;
  localparam int QSTC_MT_VAL_HI    = 5;

  // gate register field
  localparam int QSTC_GATE_BIT     = 0;

  // reset values
  localparam logic [7:0] QSTC_RST_CONTROL = 8'h00;
  localparam logic [7:0] QSTC_RST_STATUS  = 8'h00;
  localparam logic [7:0] QSTC_RST_COUNT   = 8'h00;
  localparam logic [5:0] QSTC_RST_MATCH   = 6'h00;
  localparam logic       QSTC_RST_GATE    = 1'b1;

  // clock source codes
  typedef enum logic [1:0] {
    QSTC_SRC_OSC  = 2'b00,
    QSTC_SRC_LOSC = 2'b01,
    QSTC_SRC_IREF = 2'b10,
    QSTC_SRC_RSVD = 2'b11
  } qstc_src_t;

  // power modes
  typedef enum logic [2:0] {
    QSTC_PM_RUN    = 3'b000,
    QSTC_PM_LORUN  = 3'b001,
    QSTC_PM_WAIT   = 3'b010,
    QSTC_PM_LOWAIT = 3'b011,
    QSTC_PM_STOP3  = 3'b100,
    QSTC_PM_STOP2  = 3'b101
  } qstc_pm_t;

  // first stage: reference edges per derived clock period
  // codes 000..111: 1k, 32.768k, 32k, 38.4k, 4.9152M, 4M, 8M, 16M
  localparam logic [8:0] QSTC_PRE1_DIV [0:7] = '{
    9'h001, 9'h001, 9'h001, 9'h001, 9'h080, 9'h07D, 9'h0FA, 9'h1F4};
  // second stage: derived clock periods per quarter second (4 Hz)
  localparam logic [13:0] QSTC_PRE2_DIV [0:7] = '{
    14'h00FA, 14'h2000, 14'h1F40, 14'h2580,
    14'h2580, 14'h1F40, 14'h1F40, 14'h1F40};

  localparam logic [1:0] QSTC_SEC_PHASE = 2'b00;

endpackage

//--- qstc_edge_sync.sv
// two-flop synchroniser with rising-edge detect for one reference clock pin.
// assumes the pin is asynchronous to clock and slower than half its rate.
`timescale 1ns/1ps
module qstc_edge_sync (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic meta_r;
  logic sync_r;
  logic prev_r;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= pin;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign level = sync_r;
  assign rise  = sync_r & ~prev_r;

endmodule

//--- qstc_time_counter.sv
// quarter-second time counter: prescaler, 8-bit counter, match, events,
// derived clock output and Avalon-MM register slave.
// assumes reference clocks arrive as asynchronous pins and power_mode comes
// from the system power controller on the same clock.
`timescale 1ns/1ps
module qstc_time_counter #(
  parameter int unsigned div_shift = 0
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        internal_reference_clock,
  input  wire logic        crystal_oscillator_output,
  input  wire logic        low_power_oscillator,
  input  wire logic [2:0]  power_mode,
  input  wire logic        adc_hw_trigger_select,
  output logic             irq,
  output logic             wake_request,
  output logic             adc_trigger,
  output logic             derived_clock_out
);

  // control and status state
  logic        enable_r;
  logic [1:0]  clock_source_select_r;
  logic        clkout_en_r;
  logic [2:0]  prescaler_select_r;
  logic        qsec_flag_r;
  logic        sec_flag_r;
  logic        match_flag_r;
  logic        qsec_ie_r;
  logic        sec_ie_r;
  logic        match_irq_enable_r;
  logic        match_enable_r;
  logic [5:0]  match_val_r;
  logic        gate_r;
  logic [7:0]  count_r;
  logic [8:0]  pre1_r;
  logic [13:0] pre2_r;

  // bus handshake and registered outputs
  logic        wait_r;
  logic [31:0] rdata_r;
  logic        irq_r;
  logic        wake_r;
  logic        adc_r;
  logic        dclk_r;

  // synchronised reference clocks
  logic osc_lvl;
  logic osc_rise;
  logic losc_lvl;
  logic losc_rise;
  logic iref_lvl;
  logic iref_rise;

  qstc_edge_sync u_sync_osc (
    .clock (clock),
    .reset (reset),
    .pin   (crystal_oscillator_output),
    .level (osc_lvl),
    .rise  (osc_rise)
  );

  qstc_edge_sync u_sync_losc (
    .clock (clock),
    .reset (reset),
    .pin   (low_power_oscillator),
    .level (losc_lvl),
    .rise  (losc_rise)
  );

  qstc_edge_sync u_sync_iref (
    .clock (clock),
    .reset (reset),
    .pin   (internal_reference_clock),
    .level (iref_lvl),
    .rise  (iref_rise)
  );

  // source selection
  logic ref_rise;
  logic ref_lvl;
  logic stop2;

  assign stop2 = (power_mode == qstc_pkg::QSTC_PM_STOP2);

  always_comb begin
    ref_rise = 1'b0;
    ref_lvl  = 1'b0;
    case (clock_source_select_r)
      qstc_pkg::QSTC_SRC_OSC: begin
        ref_rise = osc_rise;
        ref_lvl  = osc_lvl;
      end
      qstc_pkg::QSTC_SRC_LOSC: begin
        ref_rise = losc_rise;
        ref_lvl  = losc_lvl;
      end
      qstc_pkg::QSTC_SRC_IREF: begin
        ref_rise = iref_rise & ~stop2;
        ref_lvl  = iref_lvl & ~stop2;
      end
      default: begin
        ref_rise = 1'b0;
        ref_lvl  = 1'b0;
      end
    endcase
  end

  // prescaler divisors
  logic [8:0]  div1;
  logic [13:0] div2_raw;
  logic [13:0] div2;

  assign div1     = qstc_pkg::QSTC_PRE1_DIV[prescaler_select_r];
  assign div2_raw = qstc_pkg::QSTC_PRE2_DIV[prescaler_select_r] >> div_shift;
  assign div2     = (div2_raw == 14'h0000) ? 14'h0001 : div2_raw;

  // bus decode
  logic        bus_req;
  logic        bus_go;
  logic        wr_go;
  logic        wr_ctl;
  logic        wr_st;
  logic        wr_mt;
  logic        clear_req;
  logic [7:0]  wd;

  assign bus_req   = avs_read | avs_write;
  assign bus_go    = bus_req & ~wait_r;
  assign wd        = avs_writedata[7:0];
  assign wr_go     = bus_go & avs_write & avs_byteenable[0];
  assign wr_ctl    = wr_go & gate_r & (avs_address == qstc_pkg::QSTC_OFS_CONTROL);
  assign wr_st     = wr_go & gate_r & (avs_address == qstc_pkg::QSTC_OFS_STATUS);
  assign wr_mt     = wr_go & gate_r & (avs_address == qstc_pkg::QSTC_OFS_MATCH);
  assign clear_req = wr_ctl & wd[qstc_pkg::QSTC_CTL_CLEAR];

  // time base
  logic        pre1_done;
  logic        tick;
  logic [7:0]  count_inc;
  logic        match_hit;
  logic        sec_hit;

  assign pre1_done = ref_rise & (pre1_r >= div1 - 9'h001);
  assign tick      = enable_r & pre1_done & (pre2_r >= div2 - 14'h0001);
  assign count_inc = count_r + 8'h01;
  assign match_hit = tick & match_enable_r & (count_inc == {match_val_r, 2'b00});
  assign sec_hit   = tick & (count_inc[1:0] == qstc_pkg::QSTC_SEC_PHASE);

  always_ff @(posedge clock) begin
    if (reset || !enable_r || clear_req) begin
      pre1_r <= 9'h000;
      pre2_r <= 14'h0000;
    end else if (ref_rise) begin
      if (pre1_done) begin
        pre1_r <= 9'h000;
        if (pre2_r >= div2 - 14'h0001) begin
          pre2_r <= 14'h0000;
        end else begin
          pre2_r <= pre2_r + 14'h0001;
        end
      end else begin
        pre1_r <= pre1_r + 9'h001;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset || !enable_r || clear_req) begin
      count_r <= qstc_pkg::QSTC_RST_COUNT;
    end else if (match_hit) begin
      count_r <= 8'h00;
    end else if (tick) begin
      count_r <= count_inc;
    end
  end

  // control register; kept across power mode changes
  always_ff @(posedge clock) begin
    if (reset) begin
      enable_r              <= qstc_pkg::QSTC_RST_CONTROL[qstc_pkg::QSTC_CTL_ENABLE];
      clock_source_select_r <= qstc_pkg::QSTC_RST_CONTROL[qstc_pkg::QSTC_CTL_SRC_HI:
                                                          qstc_pkg::QSTC_CTL_SRC_LO];
      clkout_en_r           <= qstc_pkg::QSTC_RST_CONTROL[qstc_pkg::QSTC_CTL_CLKOUT];
      prescaler_select_r    <= qstc_pkg::QSTC_RST_CONTROL[qstc_pkg::QSTC_CTL_PS_HI:
                                                          qstc_pkg::QSTC_CTL_PS_LO];
    end else if (wr_ctl) begin
      enable_r              <= wd[qstc_pkg::QSTC_CTL_ENABLE];
      clock_source_select_r <= wd[qstc_pkg::QSTC_CTL_SRC_HI:qstc_pkg::QSTC_CTL_SRC_LO];
      clkout_en_r           <= wd[qstc_pkg::QSTC_CTL_CLKOUT];
      prescaler_select_r    <= wd[qstc_pkg::QSTC_CTL_PS_HI:qstc_pkg::QSTC_CTL_PS_LO];
    end
  end

  // interrupt enables
  always_ff @(posedge clock) begin
    if (reset) begin
      qsec_ie_r          <= qstc_pkg::QSTC_RST_STATUS[qstc_pkg::QSTC_ST_QSEC_IE];
      sec_ie_r           <= qstc_pkg::QSTC_RST_STATUS[qstc_pkg::QSTC_ST_SEC_IE];
      match_irq_enable_r <= qstc_pkg::QSTC_RST_STATUS[qstc_pkg::QSTC_ST_MATCH_IE];
    end else if (wr_st) begin
      qsec_ie_r          <= wd[qstc_pkg::QSTC_ST_QSEC_IE];
      sec_ie_r           <= wd[qstc_pkg::QSTC_ST_SEC_IE];
      match_irq_enable_r <= wd[qstc_pkg::QSTC_ST_MATCH_IE];
    end
  end

  // sticky event flags: a new event wins over a write-one clear
  always_ff @(posedge clock) begin
    if (reset) begin
      qsec_flag_r  <= qstc_pkg::QSTC_RST_STATUS[qstc_pkg::QSTC_ST_QSEC_F];
      sec_flag_r   <= qstc_pkg::QSTC_RST_STATUS[qstc_pkg::QSTC_ST_SEC_F];
      match_flag_r <= qstc_pkg::QSTC_RST_STATUS[qstc_pkg::QSTC_ST_MATCH_F];
    end else begin
      if (tick) begin
        qsec_flag_r <= 1'b1;
      end else if (wr_st && wd[qstc_pkg::QSTC_ST_QSEC_F]) begin
        qsec_flag_r <= 1'b0;
      end
      if (sec_hit) begin
        sec_flag_r <= 1'b1;
      end else if (wr_st && wd[qstc_pkg::QSTC_ST_SEC_F]) begin
        sec_flag_r <= 1'b0;
      end
      if (match_hit) begin
        match_flag_r <= 1'b1;
      end else if (wr_st && wd[qstc_pkg::QSTC_ST_MATCH_F]) begin
        match_flag_r <= 1'b0;
      end
    end
  end

  // match register
  always_ff @(posedge clock) begin
    if (reset) begin
      match_enable_r <= 1'b0;
      match_val_r    <= qstc_pkg::QSTC_RST_MATCH;
    end else if (wr_mt) begin
      match_enable_r <= wd[qstc_pkg::QSTC_MT_ENABLE];
      match_val_r    <= wd[qstc_pkg::QSTC_MT_VAL_HI:0];
    end
  end

  // bus clock gate; writable even while gated so software can reopen it
  always_ff @(posedge clock) begin
    if (reset) begin
      gate_r <= qstc_pkg::QSTC_RST_GATE;
    end else if (wr_go && avs_address == qstc_pkg::QSTC_OFS_GATE) begin
      gate_r <= wd[qstc_pkg::QSTC_GATE_BIT];
    end
  end

  // interrupt, wake and adc trigger
  logic irq_nxt;

  assign irq_nxt = (qsec_flag_r & qsec_ie_r) | (sec_flag_r & sec_ie_r)
                 | (match_flag_r & match_irq_enable_r);

  always_ff @(posedge clock) begin
    if (reset) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
      adc_r  <= 1'b0;
    end else begin
      irq_r  <= irq_nxt;
      wake_r <= irq_nxt & (power_mode != qstc_pkg::QSTC_PM_RUN);
      adc_r  <= match_hit & adc_hw_trigger_select;
    end
  end

  // derived clock output; stops in stop2 when the internal reference is the source
  logic dclk_nxt;

  always_comb begin
    if (!clkout_en_r) begin
      dclk_nxt = 1'b0;
    end else if (div1 == 9'h001) begin
      dclk_nxt = ref_lvl;
    end else begin
      dclk_nxt = (pre1_r < (div1 >> 1));
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dclk_r <= 1'b0;
    end else begin
      dclk_r <= dclk_nxt;
    end
  end

  // read mux
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    case (avs_address)
      qstc_pkg::QSTC_OFS_CONTROL:
        rd_byte = {enable_r, clock_source_select_r, 1'b0, clkout_en_r,
                   prescaler_select_r};
      qstc_pkg::QSTC_OFS_STATUS:
        rd_byte = {qsec_flag_r, sec_flag_r, match_flag_r, qsec_ie_r, sec_ie_r,
                   match_irq_enable_r, 2'b00};
      qstc_pkg::QSTC_OFS_COUNT:
        rd_byte = count_r;
      qstc_pkg::QSTC_OFS_MATCH:
        rd_byte = {match_enable_r, 1'b0, match_val_r};
      qstc_pkg::QSTC_OFS_GATE:
        rd_byte = {7'h00, gate_r};
      default:
        rd_byte = 8'h00;
    endcase
  end

  // one wait cycle per access: data latched on the same edge that drops waitrequest
  always_ff @(posedge clock) begin
    if (reset) begin
      wait_r  <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else if (bus_go) begin
      wait_r <= 1'b1;
    end else if (bus_req) begin
      wait_r <= 1'b0;
      if (gate_r || avs_address == qstc_pkg::QSTC_OFS_GATE) begin
        rdata_r <= {24'h000000, rd_byte};
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  assign avs_readdata      = rdata_r;
  assign avs_waitrequest   = wait_r;
  assign irq               = irq_r;
  assign wake_request      = wake_r;
  assign adc_trigger       = adc_r;
  assign derived_clock_out = dclk_r;

endmodule

//--- qstc_time_counter_sva.sv
// port-level checks for the quarter-second time counter.
// assumes it is bound to qstc_time_counter with the single system clock.
`timescale 1ns/1ps
module qstc_time_counter_sva (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic [2:0]  power_mode,
  input wire logic        adc_hw_trigger_select,
  input wire logic        irq,
  input wire logic        wake_request,
  input wire logic        adc_trigger,
  input wire logic        derived_clock_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  chk_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_read_upper: assert property (
    avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  chk_reset_quiet: assert property ($past(reset) |-> avs_waitrequest && !irq
    && !wake_request && !adc_trigger && !derived_clock_out)
    else $error("outputs not idle after reset");
  chk_wake_mode: assert property (
    wake_request |-> $past(power_mode) != qstc_pkg::QSTC_PM_RUN)
    else $error("wake request in run mode");
  chk_wake_irq: assert property (wake_request |-> irq || $past(irq))
    else $error("wake request without interrupt");
  chk_adc_pulse: assert property (adc_trigger |=> !adc_trigger)
    else $error("adc trigger longer than one cycle");
  chk_adc_select: assert property (adc_trigger |-> $past(adc_hw_trigger_select))
    else $error("adc trigger while not selected");

  cov_write_taken: cover property (avs_write && !avs_waitrequest);
  cov_adc_fired: cover property (adc_trigger);
  cov_wake_fired: cover property (wake_request);
endmodule

bind qstc_time_counter qstc_time_counter_sva i_qstc_time_counter_sva (
  .clock                 (clock),
  .reset                 (reset),
  .avs_read              (avs_read),
  .avs_write             (avs_write),
  .avs_readdata          (avs_readdata),
  .avs_waitrequest       (avs_waitrequest),
  .power_mode            (power_mode),
  .adc_hw_trigger_select (adc_hw_trigger_select),
  .irq                   (irq),
  .wake_request          (wake_request),
  .adc_trigger           (adc_trigger),
  .derived_clock_out     (derived_clock_out)
);

//--- test_quarter_second_time_counter.sv
// self-checking bench for the quarter-second time counter.
// assumes div_shift 12: code 001 needs two source edges a tick, 010 one.
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("Error %0t: got %h want %h", $time, a, e); end end
module test_quarter_second_time_counter;
  localparam logic [4:0] a_ctl = qstc_pkg::QSTC_OFS_CONTROL;
  localparam logic [4:0] a_st  = qstc_pkg::QSTC_OFS_STATUS;
  localparam logic [4:0] a_cnt = qstc_pkg::QSTC_OFS_COUNT;
  localparam logic [4:0] a_mt  = qstc_pkg::QSTC_OFS_MATCH;
  localparam logic [4:0] a_gt  = qstc_pkg::QSTC_OFS_GATE;
  logic        clock;
  logic        reset;
  logic [4:0]  address;
  logic        rd;
  logic        wr_en;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic [2:0]  pins;
  logic [2:0]  mode;
  logic        adc_sel;
  logic        irq;
  logic        wake;
  logic        adc;
  logic        clk_out;
  int          failures;
  int          tests_run;
  int          cycles;
  int          adc_n;
  int          clk_n;

  qstc_time_counter #(.div_shift(12)) i_qstc_time_counter (
    .clock(clock), .reset(reset), .avs_address(address), .avs_read(rd),
    .avs_write(wr_en), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .internal_reference_clock(pins[2]), .crystal_oscillator_output(pins[1]),
    .low_power_oscillator(pins[0]), .power_mode(mode),
    .adc_hw_trigger_select(adc_sel), .irq(irq), .wake_request(wake),
    .adc_trigger(adc), .derived_clock_out(clk_out));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic results;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (adc === 1'b1) adc_n++;
    if (clk_out === 1'b1) clk_n++;
    if (cycles == 6000) begin
      failures++;
      results;
    end
  end

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    address <= a;
    wdata <= {24'h000000, d};
    if (w) wr_en <= 1'b1;
    else rd <= 1'b1;
    do @(posedge clock); while (waitreq !== 1'b0);
    q = rdata[7:0];
    wr_en <= 1'b0;
    rd <= 1'b0;
    @(posedge clock);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic chk_rd(input logic [4:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask

  // one source edge per step; high and low each four cycles
  task automatic pulse(input logic [2:0] m, input int n);
    repeat (n) begin
      pins <= m;
      repeat (4) @(posedge clock);
      pins <= 3'b000;
      repeat (4) @(posedge clock);
    end
    repeat (4) @(posedge clock);
  endtask

  task automatic t_regs;
    chk_rd(a_ctl, 8'h00);
    chk_rd(a_st, 8'h00);
    chk_rd(a_cnt, 8'h00);
    chk_rd(a_mt, 8'h00);
    chk_rd(a_gt, 8'h01);
    chk_rd(5'h14, 8'h00);
    wr(a_ctl, 8'h1B);
    chk_rd(a_ctl, 8'h0B);
  endtask

  task automatic t_src;
    logic [2:0] mk [3] = '{3'b010, 3'b001, 3'b100};
    for (int s = 0; s < 3; s++) begin
      wr(a_ctl, {1'b1, 2'(s), 5'h11});
      pulse(~mk[s], 4);
      chk_rd(a_cnt, 8'h00);
      pulse(mk[s], 6);
      chk_rd(a_cnt, 8'h03);
    end
    wr(a_ctl, 8'hB2);
    pulse(3'b001, 3);
    chk_rd(a_cnt, 8'h03);
  endtask

  task automatic t_flags;
    wr(a_st, 8'hF0);
    wr(a_ctl, 8'hB1);
    pulse(3'b001, 2);
    `CHK(irq, 1'b1)
    chk_rd(a_st, 8'h90);
    pulse(3'b001, 6);
    chk_rd(a_st, 8'hD0);
    wr(a_st, 8'hC8);
    chk_rd(a_st, 8'h08);
    pulse(3'b001, 2);
    `CHK(irq, 1'b0)
  endtask

  task automatic t_match;
    wr(a_st, 8'hE0);
    adc_sel <= 1'b1;
    mode <= qstc_pkg::QSTC_PM_LOWAIT;
    wr(a_mt, 8'h81);
    wr(a_ctl, 8'hB1);
    pulse(3'b001, 8);
    `CHK(adc_n, 1)
    chk_rd(a_cnt, 8'h00);
    chk_rd(a_st, 8'hE0);
    `CHK(wake, 1'b0)
    wr(a_st, 8'hE4);
    adc_sel <= 1'b0;
    pulse(3'b001, 8);
    `CHK(irq, 1'b1)
    `CHK(wake, 1'b1)
    `CHK(adc_n, 1)
    wr(a_mt, 8'h01);
    pulse(3'b001, 8);
    chk_rd(a_cnt, 8'h04);
  endtask

  task automatic t_lp;
    wr(a_st, 8'hE0);
    wr(a_ctl, 8'hD1);
    mode <= qstc_pkg::QSTC_PM_STOP2;
    pulse(3'b100, 4);
    chk_rd(a_cnt, 8'h00);
    mode <= qstc_pkg::QSTC_PM_STOP3;
    pulse(3'b100, 4); // internal reference kept running in stop3
    chk_rd(a_cnt, 8'h02);
    `CHK(clk_n, 0)
    wr(a_ctl, 8'hB9);
    mode <= qstc_pkg::QSTC_PM_STOP2;
    pulse(3'b001, 4);
    `CHK(clk_n > 0, 1'b1)
    chk_rd(a_cnt, 8'h02);
    wr(a_ctl, 8'h99);
    pulse(3'b010, 4); // crystal kept running in stop2
    chk_rd(a_cnt, 8'h02);
    mode <= qstc_pkg::QSTC_PM_RUN;
    chk_rd(a_mt, 8'h01);
  endtask

  task automatic t_gate;
    wr(a_gt, 8'h00);
    wr(a_mt, 8'h85);
    chk_rd(a_mt, 8'h00);
    chk_rd(a_gt, 8'h00);
    wr(a_gt, 8'h01);
    chk_rd(a_mt, 8'h01);
    be <= 4'hE;
    wr(a_mt, 8'h85);
    be <= 4'hF;
    chk_rd(a_mt, 8'h01);
    wr(a_gt, 8'h00);
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    chk_rd(a_gt, 8'h01);
    chk_rd(a_mt, 8'h00);
  endtask

  initial begin
    reset = 1'b1;
    address = 5'h00;
    rd = 1'b0;
    wr_en = 1'b0;
    wdata = 32'h00000000;
    be = 4'hF;
    pins = 3'b000;
    mode = qstc_pkg::QSTC_PM_RUN;
    adc_sel = 1'b0;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    repeat (2) @(posedge clock);
    t_regs;
    t_src;
    t_flags;
    t_match;
    t_lp;
    t_gate;
    results;
  end
endmodule
